// [src/serial_output_freeze_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "freeze_defines.svh"

module serial_output_freeze_control #(
	parameter int FREEZE_BITS = `FRZ_WIDTH
) (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// Serial freeze port, on the controller's free-running clock
	input  wire logic               freeze_shift_clock,
	input  wire logic               freeze_serial_data,
	// Ungated clocks from the dividers, on clock
	input  wire logic [3:0]         group_a_source,
	input  wire logic [3:0]         group_b_source,
	input  wire logic [2:0]         group_c_upper_source,
	input  wire logic               group_c_first_source,
	input  wire logic               feedback_source,
	input  wire logic               coincident_edge_source,
	// Gated output clocks
	output logic [3:0]              group_a_outputs,
	output logic [3:0]              group_b_outputs,
	output logic [2:0]              group_c_upper_outputs,
	output logic                    group_c_first_output,
	output logic                    feedback_output,
	output logic                    coincident_edge_indicator,
	// Status
	output logic [FREEZE_BITS-1:0]  freeze_enable_bits,
	output logic                    freeze_load_done
);

	// ==============================================================
	// Elaboration checks
	// The receiver, the layout macros and the port widths must agree,
	// or an output would be gated by the wrong enable bit.
	generate
		if (FREEZE_BITS != `FRZ_WIDTH) begin : g_bad_width
			$error("FREEZE_BITS must equal the twelve-bit freeze word");
		end
		if (`FRZ_OUT_COUNT != `FRZ_WIDTH + 2) begin : g_bad_count
			$error("Output vector must be the freeze word plus two fixed outputs");
		end
		if (`FRZ_OUT_CFIRST < `FRZ_WIDTH || `FRZ_OUT_FB < `FRZ_WIDTH) begin : g_bad_fixed
			$error("Fixed outputs must lie above the freeze word");
		end
		if (`FRZ_OUT_CFIRST == `FRZ_OUT_FB) begin : g_bad_share
			$error("Fixed outputs must not share a slot");
		end
		if (`FRZ_SYNC_BIT >= `FRZ_WIDTH) begin : g_bad_sync
			$error("Indicator enable must lie inside the freeze word");
		end
		if (`FRZ_LAST_BIT != `FRZ_WIDTH - 1) begin : g_bad_last
			$error("Receiver must stop after one bit per enable");
		end
		if ((1 << `FRZ_CNT_W) <= `FRZ_WIDTH - 1) begin : g_bad_cnt
			$error("Receiver counter too narrow for the frame");
		end
		if (`FRZ_C_LSB + 3 > `FRZ_SYNC_BIT) begin : g_bad_group
			$error("Group C enables overlap the indicator enable");
		end
	endgenerate

	// ==============================================================
	// Receiver in the shift-clock domain
	logic [`FRZ_WIDTH-1:0]      rx_word;
	logic                       rx_toggle;

	freeze_serial_rx u_rx (
		.freeze_shift_clock (freeze_shift_clock),
		.sys_rst            (sys_rst),
		.freeze_serial_data (freeze_serial_data),
		.word_q             (rx_word),
		.word_toggle_q      (rx_toggle)
	);

	// ==============================================================
	// Toggle crossing into clock
	// The received word is held for a whole frame after the toggle,
	// far longer than the three cycles needed here, so it is sampled
	// as a quasi-static bus once the toggle has been synchronised.
	// Limitation: reset must outlast three shift-clock edges, or a
	// toggle left over from before reset could load a stale word.
	logic                       tog_meta_q, tog_meta_d;
	logic                       tog_sync_q, tog_sync_d;
	logic                       tog_seen_q, tog_seen_d;
	logic                       load_now;

	always_comb begin
		tog_meta_d = rx_toggle;
		tog_sync_d = tog_meta_q;
		tog_seen_d = tog_sync_q;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tog_meta_q <= 1'b0;
			tog_sync_q <= 1'b0;
			tog_seen_q <= 1'b0;
		end else begin
			tog_meta_q <= tog_meta_d;
			tog_sync_q <= tog_sync_d;
			tog_seen_q <= tog_seen_d;
		end
	end

	assign load_now = tog_sync_q ^ tog_seen_q;

	// ==============================================================
	// Freeze-enable register
	logic [`FRZ_WIDTH-1:0]      freeze_enable_q, freeze_enable_d;
	logic                       load_done_q, load_done_d;

	always_comb begin
		freeze_enable_d = freeze_enable_q;
		load_done_d     = 1'b0;
		// Only a complete frame is ever applied
		// Done rises with the new word, so both are read in one cycle
		if (load_now) begin
			freeze_enable_d = rx_word;
			load_done_d     = 1'b1;
		end
	end

	// Power-up leaves every output running
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			freeze_enable_q <= `FRZ_RESET;
			load_done_q     <= 1'b0;
		end else begin
			freeze_enable_q <= freeze_enable_d;
			load_done_q     <= load_done_d;
		end
	end

	assign freeze_enable_bits = freeze_enable_q;
	assign freeze_load_done   = load_done_q;

	// ==============================================================
	// Per-output request and source vectors
	logic [`FRZ_OUT_COUNT-1:0]  src_vec;
	logic [`FRZ_OUT_COUNT-1:0]  req_vec;

	always_comb begin
		src_vec = '0;
		src_vec[`FRZ_A_LSB +: 4] = group_a_source;
		src_vec[`FRZ_B_LSB +: 4] = group_b_source;
		src_vec[`FRZ_C_LSB +: 3] = group_c_upper_source;
		src_vec[`FRZ_SYNC_BIT]   = coincident_edge_source;
		src_vec[`FRZ_OUT_CFIRST] = group_c_first_source;
		src_vec[`FRZ_OUT_FB]     = feedback_source;
	end

	// Only the twelve gated outputs take a bit of the word
	always_comb begin
		req_vec = '0;
		req_vec[`FRZ_A_LSB +: 4] = freeze_enable_q[`FRZ_A_LSB +: 4];
		req_vec[`FRZ_B_LSB +: 4] = freeze_enable_q[`FRZ_B_LSB +: 4];
		req_vec[`FRZ_C_LSB +: 3] = freeze_enable_q[`FRZ_C_LSB +: 3];
		req_vec[`FRZ_SYNC_BIT]   = freeze_enable_q[`FRZ_SYNC_BIT];
		// A bad load must never stop the loop reference
		req_vec[`FRZ_OUT_CFIRST] = 1'b1;
		req_vec[`FRZ_OUT_FB]     = 1'b1;
	end

	// ==============================================================
	// Glitch-free gating
	// The sources are never stopped; only the output stage is masked,
	// so a released output comes back in phase with the rest.
	// The gate follows its request only while the source is low, so
	// neither a freeze nor a release can cut or start a high phase.
	wire logic [`FRZ_OUT_COUNT-1:0] out_vec;

	genvar gi;
	generate
		for (gi = 0; gi < `FRZ_OUT_COUNT; gi++) begin : g_gate
			logic gate_q, gate_d;
			logic pin_q, pin_d;

			always_comb begin
				gate_d = gate_q;
				if (!src_vec[gi]) begin
					gate_d = req_vec[gi];
				end
			end

			// Reset opens every gate so outputs run as soon as reset ends
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					gate_q <= 1'b1;
				end else begin
					gate_q <= gate_d;
				end
			end

			// Masking only the output keeps the source phase intact
			always_comb begin
				pin_d = src_vec[gi] & gate_d;
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					pin_q <= 1'b0;
				end else begin
					pin_q <= pin_d;
				end
			end

			assign out_vec[gi] = pin_q;
		end
	endgenerate

	// ==============================================================
	// Output ports
	assign group_a_outputs           = out_vec[`FRZ_A_LSB +: 4];
	assign group_b_outputs           = out_vec[`FRZ_B_LSB +: 4];
	assign group_c_upper_outputs     = out_vec[`FRZ_C_LSB +: 3];
	assign coincident_edge_indicator = out_vec[`FRZ_SYNC_BIT];
	assign group_c_first_output      = out_vec[`FRZ_OUT_CFIRST];
	assign feedback_output           = out_vec[`FRZ_OUT_FB];

endmodule : serial_output_freeze_control
`default_nettype wire

// [common/freeze_defines.svh]
// What this block does
// - Twelve-bit freeze-enable register gates twelve outputs
// - Feedback and first group-C output never freeze
// - Enable bit zero freezes output low
// - Enable bit one lets output toggle
// - Freeze takes effect only at natural low
// - Release takes effect only at natural low
// - Bits sampled on shift-clock rising edge
// - Bits 0-10 map to groups A, B, C
// - Bit 11 enables coincident-edge indicator
`ifndef FREEZE_DEFINES_SVH
`define FREEZE_DEFINES_SVH

// ==============================================================
// Freeze word layout
`define FRZ_WIDTH       12
`define FRZ_RESET       12'hFFF
`define FRZ_A_LSB       0
`define FRZ_B_LSB       4
`define FRZ_C_LSB       8
`define FRZ_SYNC_BIT    11
`define FRZ_START_LEVEL 1'b0

// ==============================================================
// Output vector layout
`define FRZ_OUT_COUNT   14
`define FRZ_OUT_CFIRST  12
`define FRZ_OUT_FB      13

// ==============================================================
// Receiver counter
`define FRZ_CNT_W       4
`define FRZ_LAST_BIT    4'hB

`endif

// [common/freeze_pkg.sv]
package freeze_pkg;

	typedef logic [11:0] freeze_word_t;

	// Gray order along the idle -> shift -> idle path
	typedef enum logic [1:0] {
		RX_IDLE  = 2'h0,
		RX_SHIFT = 2'h1
	} rx_state_t;

endpackage : freeze_pkg

// [src/freeze_serial_rx.sv]
`timescale 1ns/1ps
`default_nettype none
`include "freeze_defines.svh"

module freeze_serial_rx (
	input  wire logic               freeze_shift_clock,
	input  wire logic               sys_rst,
	input  wire logic               freeze_serial_data,
	output logic [`FRZ_WIDTH-1:0]   word_q,
	output logic                    word_toggle_q
);

	// ==============================================================
	// Reset into the shift-clock domain
	logic                       rst_meta_q;
	logic                       rst_link_q;

	always_ff @(posedge freeze_shift_clock) begin
		rst_meta_q <= sys_rst;
		rst_link_q <= rst_meta_q;
	end

	// ==============================================================
	// Frame receiver
	freeze_pkg::rx_state_t      state_q, state_d;
	logic [`FRZ_CNT_W-1:0]      cnt_q, cnt_d;
	logic [`FRZ_WIDTH-1:0]      shift_q, shift_d;
	logic [`FRZ_WIDTH-1:0]      word_d;
	logic                       word_toggle_d;

	always_comb begin
		state_d       = state_q;
		cnt_d         = cnt_q;
		shift_d       = shift_q;
		word_d        = word_q;
		word_toggle_d = word_toggle_q;
		case (state_q)
			freeze_pkg::RX_IDLE: begin
				// Data is sampled once per rising edge; the controller times it to be valid
				if (freeze_serial_data == `FRZ_START_LEVEL) begin
					state_d = freeze_pkg::RX_SHIFT;
					cnt_d   = '0;
				end
			end
			freeze_pkg::RX_SHIFT: begin
				// First data bit lands in bit 0 after twelve shifts
				shift_d = {freeze_serial_data, shift_q[`FRZ_WIDTH-1:1]};
				cnt_d   = cnt_q + `FRZ_CNT_W'(1);
				if (cnt_q == `FRZ_LAST_BIT) begin
					state_d       = freeze_pkg::RX_IDLE;
					word_d        = {freeze_serial_data, shift_q[`FRZ_WIDTH-1:1]};
					word_toggle_d = ~word_toggle_q;
				end
			end
			default: begin
				state_d = freeze_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge freeze_shift_clock) begin
		if (rst_link_q) begin
			state_q       <= freeze_pkg::RX_IDLE;
			cnt_q         <= '0;
			shift_q       <= `FRZ_RESET;
			word_q        <= `FRZ_RESET;
			word_toggle_q <= 1'b0;
		end else begin
			state_q       <= state_d;
			cnt_q         <= cnt_d;
			shift_q       <= shift_d;
			word_q        <= word_d;
			word_toggle_q <= word_toggle_d;
		end
	end

endmodule : freeze_serial_rx
`default_nettype wire

// [bench/serial_output_freeze_control_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_output_freeze_control_monitor #(
	parameter int FREEZE_BITS = 12
) (
	input wire logic                   clock,
	input wire logic                   sys_rst,
	input wire logic [3:0]             group_a_source,
	input wire logic [3:0]             group_a_outputs,
	input wire logic                   group_c_first_source,
	input wire logic                   group_c_first_output,
	input wire logic                   feedback_source,
	input wire logic                   feedback_output,
	input wire logic                   coincident_edge_source,
	input wire logic                   coincident_edge_indicator,
	input wire logic [FREEZE_BITS-1:0] freeze_enable_bits,
	input wire logic                   freeze_load_done
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// ==========
	// Checks
	a_feedback_free: assert property (!$past(sys_rst) |->
		feedback_output == $past(feedback_source)) else $error("feedback output gated");
	a_cfirst_free: assert property (!$past(sys_rst) |->
		group_c_first_output == $past(group_c_first_source)) else $error("c first gated");
	a_no_early_high: assert property (!$past(sys_rst) |->
		(group_a_outputs & ~$past(group_a_source)) == 4'h0) else $error("early high");
	a_no_early_low: assert property (!$past(sys_rst) |->
		($past(group_a_outputs) & $past(group_a_source) & ~group_a_outputs) == 4'h0)
		else $error("early low");
	a_sync_frozen: assert property ((!freeze_enable_bits[11] && !coincident_edge_source) ##1
		!freeze_enable_bits[11] [*2] |=> !coincident_edge_indicator) else $error("not frozen");
	a_sync_running: assert property ((freeze_enable_bits[11] && !coincident_edge_source) ##1
		freeze_enable_bits[11] [*2] |=> coincident_edge_indicator == $past(coincident_edge_source))
		else $error("not running");
	a_apply_then_done: assert property ($changed(freeze_enable_bits) |-> freeze_load_done)
		else $error("no done pulse");
	a_done_single: assert property (freeze_load_done |=> !freeze_load_done)
		else $error("done too long");
	cover property (freeze_load_done);
	cover property ($fell(freeze_enable_bits[11]));
	cover property ($fell(coincident_edge_indicator) && !freeze_enable_bits[11]);
endmodule : serial_output_freeze_control_monitor
bind serial_output_freeze_control serial_output_freeze_control_monitor #(
	.FREEZE_BITS(FREEZE_BITS)
) serial_output_freeze_control_monitor_inst (
	.clock(clock),
	.sys_rst(sys_rst),
	.group_a_source(group_a_source),
	.group_a_outputs(group_a_outputs),
	.group_c_first_source(group_c_first_source),
	.group_c_first_output(group_c_first_output),
	.feedback_source(feedback_source),
	.feedback_output(feedback_output),
	.coincident_edge_source(coincident_edge_source),
	.coincident_edge_indicator(coincident_edge_indicator),
	.freeze_enable_bits(freeze_enable_bits),
	.freeze_load_done(freeze_load_done)
);
`default_nettype wire

// [bench/freeze_controller_model.sv]
`timescale 1ns/1ps
`default_nettype none
module freeze_controller_model (
	input wire logic freeze_shift_clock,
	output var logic freeze_serial_data
);
	// Pulled-up line rests high between frames
	initial freeze_serial_data = 1'b1;
	// Data moves on the falling edge so it is settled at the sampling rise
	task send(input logic [11:0] w, input logic idle);
		int i;
		@(negedge freeze_shift_clock) freeze_serial_data <= 1'b0;
		for (i = 0; i < 12; i++) begin
			@(negedge freeze_shift_clock) freeze_serial_data <= w[i];
		end
		if (idle) begin
			@(negedge freeze_shift_clock) freeze_serial_data <= 1'b1;
		end
	endtask : send
endmodule : freeze_controller_model
`default_nettype wire

// [bench/tb_serial_output_freeze_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_serial_output_freeze_control;
	logic        clock, sys_rst, freeze_shift_clock, sdata;
	logic [7:0]  cnt;
	wire  [11:0] src, outs, bits;
	wire         fb_o, cf_o, done;
	int          miscompares, n_checks;
	// Divider stand-ins: counter bits give several rates and phases
	assign src = {cnt[2], cnt[5:3], cnt[4:1], cnt[3:0]};
	serial_output_freeze_control serial_output_freeze_control_inst (
		.clock(clock), .sys_rst(sys_rst),
		.freeze_shift_clock(freeze_shift_clock), .freeze_serial_data(sdata),
		.group_a_source(src[3:0]), .group_b_source(src[7:4]),
		.group_c_upper_source(src[10:8]), .group_c_first_source(cnt[2]),
		.feedback_source(cnt[1]), .coincident_edge_source(src[11]),
		.group_a_outputs(outs[3:0]), .group_b_outputs(outs[7:4]),
		.group_c_upper_outputs(outs[10:8]), .group_c_first_output(cf_o),
		.feedback_output(fb_o), .coincident_edge_indicator(outs[11]),
		.freeze_enable_bits(bits), .freeze_load_done(done));
	freeze_controller_model freeze_controller_model_inst (
		.freeze_shift_clock(freeze_shift_clock), .freeze_serial_data(sdata));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		freeze_shift_clock = 1'b0;
		#1;
		forever #7.5 freeze_shift_clock = ~freeze_shift_clock;
	end
	always @(negedge clock) begin
		cnt <= cnt + 8'h01;
	end
	// ==========
	// Tasks
	task chk(input string n, input logic [11:0] e, input logic [11:0] s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	// The slowest stand-in stays high for 32 cycles; wait past that
	task gates(input logic [11:0] w);
		repeat (40) @(negedge clock);
		repeat (24) begin
			@(negedge clock);
			chk("outputs", src & w, outs);
			chk("fixed", {10'h000, cnt[2], cnt[1]}, {10'h000, cf_o, fb_o});
		end
	endtask : gates
	// p is the word that must stay applied until the frame completes
	task load(input string n, input logic [11:0] w, input logic [11:0] p);
		int i;
		freeze_controller_model_inst.send(w, 1'b1);
		for (i = 0; i < 100; i++) begin
			@(negedge clock);
			if (done === 1'b1) break;
			chk({n, " held"}, p, bits);
		end
		if (i == 100) begin
			miscompares++;
			$display("BAD %s done expected 1 seen 0", n);
			test_done;
		end
		chk(n, w, bits);
		gates(w);
		$display("%s finished", n);
	endtask : load
	task t_reset;
		chk("reset word", 12'hFFF, bits);
		gates(12'hFFF);
		$display("reset finished");
	endtask : t_reset
	task t_freeze_all;
		load("freeze all", 12'h000, 12'hFFF);
	endtask : t_freeze_all
	task t_mixed;
		load("mixed", 12'hA5C, 12'h000);
	endtask : t_mixed
	// Reset cuts the frame before its trailing ones, which then idle
	task t_mid_reset;
		fork
			freeze_controller_model_inst.send(12'hFC0, 1'b1);
			begin
				repeat (8) @(negedge clock);
				sys_rst = 1'b1;
				repeat (8) @(negedge clock);
				sys_rst = 1'b0;
			end
		join
		repeat (12) begin
			@(negedge clock);
			chk("cut frame done", 12'h000, {11'h000, done});
		end
		chk("cut frame word", 12'hFFF, bits);
		gates(12'hFFF);
		$display("mid reset finished");
	endtask : t_mid_reset
	// The second start bit follows the first frame's last bit at once
	task t_back_to_back;
		freeze_controller_model_inst.send(12'h3C3, 1'b0);
		load("back to back", 12'h5A5, 12'h3C3);
	endtask : t_back_to_back
	task t_release_all;
		load("release all", 12'hFFF, 12'h5A5);
	endtask : t_release_all
	initial begin
		cnt = 8'h00;
		sys_rst = 1'b1;
		miscompares = 0;
		n_checks = 0;
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		t_reset;
		t_freeze_all;
		t_mixed;
		t_mid_reset;
		t_back_to_back;
		t_release_all;
		test_done;
	end
endmodule : tb_serial_output_freeze_control
`default_nettype wire
